// *** shared/pbc_pkg.sv ***
// Purpose: shared constants and types of the pulse batch counter
// Assumes: 25 MHz system clock, register port with 4-bit address
// Notes:   register indices are word indices on the plain register port
package pbc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int TENTH_MS      = 100;
    localparam int MENU_HOLD_MS  = 2000;
    localparam int TENTH_CYC     = TENTH_MS * (CLK_HZ / 1000);
    localparam int MENU_HOLD_CYC = MENU_HOLD_MS * (CLK_HZ / 1000);

    // ****************************************
    // register map
    // ****************************************
    typedef logic [3:0] pbc_addr_t;
    localparam pbc_addr_t REG_CTRL    = 4'h0;
    localparam pbc_addr_t REG_PRESET  = 4'h1;
    localparam pbc_addr_t REG_ADVANCE = 4'h2;
    localparam pbc_addr_t REG_DELAY   = 4'h3;
    localparam pbc_addr_t REG_DIVIDER = 4'h4;
    localparam pbc_addr_t REG_MULT    = 4'h5;
    localparam pbc_addr_t REG_CMD     = 4'h6;
    localparam pbc_addr_t REG_STATUS  = 4'h7;
    localparam pbc_addr_t REG_COUNT   = 4'h8;
    localparam pbc_addr_t REG_LATCHED = 4'h9;

    localparam int CMD_START   = 0;
    localparam int STAT_RUN    = 0;
    localparam int STAT_DELAY  = 1;
    localparam int STAT_PAUSE  = 2;
    localparam int STAT_FINE   = 3;
    localparam int STAT_MAIN   = 4;
    localparam int STAT_CHG    = 5;
    localparam int STAT_MENU   = 6;

    // ****************************************
    // values and resets
    // ****************************************
    localparam logic [9:0]  CNT_MAX     = 10'h3e7;
    localparam logic [10:0] TARGET_FULL = 11'h3e8;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [9:0]  PRESET_RST  = 10'h064;
    localparam logic [9:0]  ADV_RST     = 10'h000;
    localparam logic [9:0]  DELAY_RST   = 10'h000;
    localparam logic [7:0]  DIV_RST     = 8'h01;
    localparam logic [7:0]  MULT_RST    = 8'h01;

    typedef struct packed {
        logic [2:0] point;
        logic       main_relay_mode;
        logic       fine_relay_mode;
        logic       auto_restart_enable;
        logic       batching_mode;
        logic       count_down;
    } pbc_cfg_s;

    typedef struct packed {
        logic count_in;
        logic hold;
        logic stop;
        logic clear_start;
        logic key_enter;
        logic reset_key;
    } pbc_pins_s;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DELAY} pbc_state_e;

endpackage

// *** verilog/pbc_counter.sv ***
// Purpose: three-decade pulse counter with two-relay batching control
// Assumes: inputs already debounced and synchronous to mclk
// Notes:   restart delay resolution is one tenth of a second
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps

module pbc_counter #(
    parameter int TENTH_CYC     = pbc_pkg::TENTH_CYC,
    parameter int MENU_HOLD_CYC = pbc_pkg::MENU_HOLD_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire pbc_pkg::pbc_pins_s pins,
    input  wire logic              power_fail,
    input  wire logic [9:0]        restore_count,
    input  wire pbc_pkg::pbc_addr_t addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [15:0]            rdata,
    output logic [11:0]            count_bcd,
    output logic [2:0]             point,
    output logic                   cycle_led,
    output logic                   fine_relay,
    output logic                   main_relay,
    output logic                   menu_open,
    output logic [9:0]             saved_count
);
    import pbc_pkg::*;
    // ****************************************
    // state
    // ****************************************
    pbc_cfg_s   cfg_r;
    logic [9:0] preset_r;
    logic [9:0] adv_r;
    logic [9:0] delay_r;
    logic [7:0] div_r;
    logic [7:0] mult_r;
    logic       chg_r;
    pbc_state_e st_r;
    logic [9:0] cnt_r;
    logic [10:0] tgt_l_r;
    logic [9:0] adv_l_r;
    logic [7:0] div_cnt_r;
    logic [9:0] pend_r;
    logic       restore_r;
    logic       cin_d_r;
    logic       clr_d_r;
    logic       ke_d_r;
    logic       kr_d_r;
    logic       arm_r;
    logic       press_r;
    logic [25:0] press_cnt_r;
    logic       paused_r;
    logic [25:0] tick_cnt_r;
    logic [9:0] dly_r;
    logic       flash_r;
    logic       fine_on_r;
    logic       main_on_r;
    logic [15:0] rdata_r;
    logic [11:0] bcd_r;
    logic       led_r;
    logic       fine_rel_r;
    logic       main_rel_r;
    logic       menu_r;
    logic [9:0] saved_r;

    logic [9:0]  cnt_step;
    logic [9:0]  tgt_mod;
    logic [10:0] main_diff;
    logic [9:0]  main_up;
    logic [11:0] bcd_nxt;
    logic [15:0] stat;
    logic        up;
    logic        step;
    logic        count_en;
    logic        edge_in;
    logic        key_start;
    logic        clr_rel;
    logic        cmd_start;
    logic        auto_start;
    logic        start;
    logic        fine_hit;
    logic        main_hit;
    logic        tick;
    logic        cfg_wr;
    logic        div_wrap;
    logic [9:0]  pend_add;
    logic        fine_act;
    logic        main_act;

    function automatic logic [9:0] sat999(input logic [15:0] v);
        sat999 = (v > {6'h00, CNT_MAX}) ? CNT_MAX : v[9:0];
    endfunction
    // ****************************************
    // register port
    // ****************************************
    assign cfg_wr = wr && (addr == REG_CTRL || addr == REG_ADVANCE || addr == REG_DELAY
                    || addr == REG_DIVIDER || addr == REG_MULT);
    assign cmd_start = wr && addr == REG_CMD && wdata[CMD_START];

    // writes change settings without stopping the count; a REG_CMD start write restarts it
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            cfg_r    <= CTRL_RST;
            preset_r <= PRESET_RST;
            adv_r    <= ADV_RST;
            delay_r  <= DELAY_RST;
            div_r    <= DIV_RST;
            mult_r   <= MULT_RST;
        end
        else if (wr)
        begin
            case (addr)
                REG_CTRL:    cfg_r    <= wdata[7:0];
                REG_PRESET:  preset_r <= sat999(wdata);
                REG_ADVANCE: adv_r    <= sat999(wdata);
                REG_DELAY:   delay_r  <= sat999(wdata);
                REG_DIVIDER: div_r    <= wdata[7:0];
                REG_MULT:    mult_r   <= wdata[7:0];
                default:     ;
            endcase
        end

    // set wins over the clear of a manual start
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            chg_r <= 1'b0;
        else if (cfg_wr)
            chg_r <= 1'b1;
        else if (key_start || clr_rel || cmd_start)
            chg_r <= 1'b0;

    always_comb
    begin
        stat = 16'h0000;
        stat[STAT_RUN]   = (st_r == ST_RUN);
        stat[STAT_DELAY] = (st_r == ST_DELAY);
        stat[STAT_PAUSE] = paused_r;
        stat[STAT_FINE]  = fine_on_r;
        stat[STAT_MAIN]  = main_on_r;
        stat[STAT_CHG]   = chg_r;
        stat[STAT_MENU]  = menu_r;
    end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            rdata_r <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                REG_CTRL:    rdata_r <= {8'h00, cfg_r};
                REG_PRESET:  rdata_r <= {6'h00, preset_r};
                REG_ADVANCE: rdata_r <= {6'h00, adv_r};
                REG_DELAY:   rdata_r <= {6'h00, delay_r};
                REG_DIVIDER: rdata_r <= {8'h00, div_r};
                REG_MULT:    rdata_r <= {8'h00, mult_r};
                REG_STATUS:  rdata_r <= stat;
                REG_COUNT:   rdata_r <= {6'h00, cnt_r};
                REG_LATCHED: rdata_r <= {5'h00, tgt_l_r};
                default:     rdata_r <= 16'h0000;
            endcase
        end

    // ****************************************
    // control inputs and keys
    // ****************************************
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            cin_d_r <= 1'b0;
            clr_d_r <= 1'b0;
            ke_d_r  <= 1'b0;
            kr_d_r  <= 1'b0;
        end
        else
        begin
            cin_d_r <= pins.count_in;
            clr_d_r <= pins.clear_start;
            ke_d_r  <= pins.key_enter;
            kr_d_r  <= pins.reset_key;
        end

    assign edge_in = pins.count_in && !cin_d_r;
    assign clr_rel = clr_d_r && !pins.clear_start;
    assign key_start = arm_r && pins.key_enter && !ke_d_r;

    // reset key arms, enter confirms; in the menu reset key leaves it
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            arm_r <= 1'b0;
        else if (pins.stop || key_start)
            arm_r <= 1'b0;
        else if (pins.reset_key && !kr_d_r && !menu_r)
            arm_r <= 1'b1;

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            press_r     <= 1'b0;
            press_cnt_r <= 26'h0000000;
            paused_r    <= 1'b0;
            menu_r      <= 1'b0;
        end
        else
        begin
            if (menu_r && pins.reset_key && !kr_d_r)
                menu_r <= 1'b0;
            if (pins.key_enter && !ke_d_r && !arm_r && !menu_r)
            begin
                press_r     <= 1'b1;
                press_cnt_r <= 26'h0000000;
            end
            else if (press_r && pins.key_enter)
            begin
                if (press_cnt_r == 26'(MENU_HOLD_CYC - 1))
                begin
                    menu_r  <= 1'b1;
                    press_r <= 1'b0;
                end
                else
                    press_cnt_r <= press_cnt_r + 26'h0000001;
            end
            else if (press_r)
            begin
                paused_r <= !paused_r;
                press_r  <= 1'b0;
            end
        end

    // ****************************************
    // prescaler
    // ****************************************
    assign count_en = !pins.hold && !paused_r;
    assign step = (pend_r != 10'h000) && !start;
    assign div_wrap = (8'(div_cnt_r + 8'h01) >= div_r);
    assign pend_add = (edge_in && count_en && div_wrap) ? {2'b00, mult_r} : 10'h000;

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            div_cnt_r <= 8'h00;
            pend_r    <= 10'h000;
        end
        else if (start)
        begin
            div_cnt_r <= 8'h00;
            pend_r    <= 10'h000;
        end
        else
        begin
            if (edge_in && count_en)
                div_cnt_r <= div_wrap ? 8'h00 : div_cnt_r + 8'h01;
            pend_r <= pend_r - {9'h000, step} + pend_add;
        end

    // ****************************************
    // count and thresholds
    // ****************************************
    assign up = !cfg_r.count_down;
    assign tgt_mod = (tgt_l_r == TARGET_FULL) ? 10'h000 : tgt_l_r[9:0];
    assign main_diff = tgt_l_r - {1'b0, adv_l_r};
    assign main_up = (main_diff == TARGET_FULL) ? 10'h000 : main_diff[9:0];

    always_comb
    begin
        if (up)
            cnt_step = (cnt_r == CNT_MAX) ? 10'h000 : cnt_r + 10'h001;
        else
            cnt_step = (cnt_r == 10'h000) ? CNT_MAX : cnt_r - 10'h001;
    end

    assign fine_hit = step && st_r == ST_RUN
                      && (up ? cnt_step == tgt_mod : cnt_step == 10'h000);
    assign main_hit = step && st_r == ST_RUN
                      && (up ? cnt_step == main_up : cnt_step == adv_l_r);

    // power-up restore happens one edge after reset release
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            cnt_r     <= 10'h000;
            restore_r <= 1'b1;
        end
        else
        begin
            restore_r <= 1'b0;
            if (restore_r)
                cnt_r <= sat999({6'h00, restore_count});
            else if (start)
                cnt_r <= up ? 10'h000 : preset_r;
            else if (step)
                cnt_r <= cnt_step;
        end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            saved_r <= 10'h000;
        else if (power_fail)
            saved_r <= cnt_r;

    // thresholds frozen for the whole cycle
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            tgt_l_r <= TARGET_FULL;
            adv_l_r <= 10'h000;
        end
        else if (start)
        begin
            tgt_l_r <= (preset_r == 10'h000) ? TARGET_FULL : {1'b0, preset_r};
            adv_l_r <= adv_r;
        end

    // ****************************************
    // cycle sequencing
    // ****************************************
    assign auto_start = st_r == ST_DELAY && dly_r == 10'h000 && !chg_r;
    assign start = (key_start || clr_rel || cmd_start || auto_start)
                   && !pins.stop;
    assign tick = (tick_cnt_r == 26'(TENTH_CYC - 1));

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            st_r <= ST_IDLE;
        else if (pins.stop)
            st_r <= ST_IDLE;
        else if (start)
            st_r <= ST_RUN;
        else
        begin
            case (st_r)
                ST_IDLE: st_r <= ST_IDLE;
                ST_RUN:
                    if (fine_hit)
                        st_r <= (cfg_r.auto_restart_enable && !chg_r)
                                ? ST_DELAY : ST_IDLE;
                ST_DELAY:
                    if (chg_r || !cfg_r.auto_restart_enable)
                        st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end

    // tick restarts at the threshold so the delay is measured from it
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            tick_cnt_r <= 26'h0000000;
        else if (fine_hit || tick)
            tick_cnt_r <= 26'h0000000;
        else
            tick_cnt_r <= tick_cnt_r + 26'h0000001;

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            dly_r   <= 10'h000;
            flash_r <= 1'b0;
        end
        else if (fine_hit)
        begin
            dly_r   <= delay_r;
            flash_r <= 1'b1;
        end
        else if (st_r == ST_DELAY && tick)
        begin
            if (dly_r != 10'h000)
                dly_r <= dly_r - 10'h001;
            flash_r <= !flash_r;
        end

    // ****************************************
    // relays
    // ****************************************
    // standard mode drives only the fine relay, reversed sense
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            fine_on_r <= 1'b0;
            main_on_r <= 1'b0;
        end
        else if (pins.stop)
        begin
            fine_on_r <= 1'b0;
            main_on_r <= 1'b0;
        end
        else if (start)
        begin
            fine_on_r <= cfg_r.batching_mode;
            main_on_r <= cfg_r.batching_mode && !(adv_r > sat999({6'h00, preset_r})
                         && preset_r != 10'h000);
        end
        else
        begin
            if (fine_hit)
                fine_on_r <= !cfg_r.batching_mode;
            if (main_hit)
                main_on_r <= 1'b0;
        end

    assign fine_act = fine_on_r && !paused_r;
    assign main_act = main_on_r && !paused_r;

    // ****************************************
    // outputs
    // ****************************************
    for (genvar d = 0; d < 3; d++)
    begin : g_decade
        localparam int P10 = (d == 0) ? 1 : (d == 1) ? 10 : 100;
        assign bcd_nxt[4*d +: 4] = 4'((32'(cnt_r) / P10) % 10);
    end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            bcd_r      <= 12'h000;
            led_r      <= 1'b0;
            fine_rel_r <= 1'b1;
            main_rel_r <= 1'b1;
        end
        else
        begin
            bcd_r      <= bcd_nxt;
            led_r      <= (st_r == ST_RUN) || (st_r == ST_DELAY && flash_r);
            fine_rel_r <= cfg_r.fine_relay_mode ? fine_act : !fine_act;
            main_rel_r <= cfg_r.main_relay_mode ? main_act : !main_act;
        end

    assign rdata       = rdata_r;
    assign count_bcd   = bcd_r;
    assign point       = cfg_r.point;
    assign cycle_led   = led_r;
    assign fine_relay  = fine_rel_r;
    assign main_relay  = main_rel_r;
    assign menu_open   = menu_r;
    assign saved_count = saved_r;

endmodule

// *** testbench/pbc_sensor_model.sv ***
// Purpose: flow sensor model feeding the counting input
// Assumes: one clean pulse per unit, line pulled low between pulses
// Notes:   slow mode stretches the gap between rising edges to 6 cycles
`timescale 1ns/10ps

module pbc_sensor_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] n_req,
    input  wire logic       go,
    input  wire logic       slow,
    output logic            count_in,
    output logic            busy
);
    // ****************
    // pulse train
    // ****************
    logic [7:0] left_r;
    logic [2:0] ph_r;
    logic       last;
    assign busy = (left_r != 8'h00);
    assign last = (ph_r == (slow ? 3'h5 : 3'h1));
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            left_r   <= 8'h00;
            ph_r     <= 3'h0;
            count_in <= 1'b0;
        end
        else if (go)
        begin
            left_r <= n_req;
            ph_r   <= 3'h0;
        end
        else if (busy)
        begin
            // edges never closer than two cycles
            count_in <= (ph_r == 3'h0);
            ph_r     <= last ? 3'h0 : ph_r + 3'h1;
            left_r   <= last ? left_r - 8'h01 : left_r;
        end
        else
            count_in <= 1'b0;
    end
endmodule

// *** testbench/pbc_counter_monitor.sv ***
// Purpose: port-level checks of the pulse batch counter
// Assumes: relay modes and point shadowed from register writes
// Notes:   hold check assumes no units pending when hold rises
`timescale 1ns/10ps

module pbc_counter_monitor #(
    parameter int MENU_HOLD_CYC = pbc_pkg::MENU_HOLD_CYC
) (
    input wire logic               mclk,
    input wire logic               rst,
    input wire pbc_pkg::pbc_pins_s pins,
    input wire logic               power_fail,
    input wire logic [9:0]         restore_count,
    input wire pbc_pkg::pbc_addr_t addr,
    input wire logic [15:0]        wdata,
    input wire logic               wr,
    input wire logic               rd,
    input wire logic [15:0]        rdata,
    input wire logic [11:0]        count_bcd,
    input wire logic [2:0]         point,
    input wire logic               cycle_led,
    input wire logic               fine_relay,
    input wire logic               main_relay,
    input wire logic               menu_open,
    input wire logic [9:0]         saved_count
);
    import pbc_pkg::*;
    // ****************
    // shadow state
    // ****************
    logic [7:0]  ctrl_r;
    logic [31:0] enter_r;
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            ctrl_r <= CTRL_RST;
        else if (wr && addr == REG_CTRL)
            ctrl_r <= wdata[7:0];
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            enter_r <= 32'h0;
        else
            enter_r <= pins.key_enter ? enter_r + 32'h1 : 32'h0;
    function automatic logic [9:0] bin_of(input logic [11:0] b);
        return 10'(b[11:8]) * 10'd100 + 10'(b[7:4]) * 10'd10 + 10'(b[3:0]);
    endfunction
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_start;
        wr && addr == REG_CMD && wdata[CMD_START] && !pins.stop;
    endsequence
    sequence s_stop;
        pins.stop[*3];
    endsequence
    property p_digits;
        count_bcd[3:0] <= 4'h9 && count_bcd[7:4] <= 4'h9 && count_bcd[11:8] <= 4'h9;
    endproperty
    property p_point;
        (wr && addr == REG_CTRL) ##1 !(wr && addr == REG_CTRL) |=> point == ctrl_r[7:5];
    endproperty
    property p_stop_relays;
        s_stop |-> fine_relay == !ctrl_r[3] && main_relay == !ctrl_r[4];
    endproperty
    property p_stop_led;
        s_stop |-> !cycle_led;
    endproperty
    property p_start_led;
        s_start ##1 !pins.stop |=> cycle_led;
    endproperty
    property p_start_zero;
        s_start ##0 (!ctrl_r[0] && !pins.count_in) ##1 !pins.count_in |=> count_bcd == 12'h000;
    endproperty
    property p_bat_fine;
        s_start ##0 ctrl_r[1] ##1 !pins.stop |=> fine_relay == ctrl_r[3];
    endproperty
    property p_power;
        power_fail |=> saved_count == bin_of(count_bcd);
    endproperty
    property p_menu;
        enter_r >= MENU_HOLD_CYC + 3 |-> menu_open;
    endproperty
    property p_hold;
        (pins.hold && !wr)[*6] |-> $stable(count_bcd);
    endproperty
    a_digits: assert property (p_digits) else $error("count digit above nine");
    a_point: assert property (p_point) else $error("point differs from control");
    a_stop_relays: assert property (p_stop_relays) else $error("relay active in stop");
    a_stop_led: assert property (p_stop_led) else $error("cycle lit in stop");
    a_start_led: assert property (p_start_led) else $error("cycle not lit on start");
    a_start_zero: assert property (p_start_zero) else $error("count not cleared");
    a_bat_fine: assert property (p_bat_fine) else $error("fine relay idle at start");
    a_power: assert property (p_power) else $error("saved count wrong");
    a_menu: assert property (p_menu) else $error("menu not opened");
    a_hold: assert property (p_hold) else $error("count moved in hold");
endmodule

bind pbc_counter pbc_counter_monitor #(.MENU_HOLD_CYC(MENU_HOLD_CYC)) i_pbc_counter_monitor (
    .mclk(mclk), .rst(rst), .pins(pins), .power_fail(power_fail),
    .restore_count(restore_count), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .count_bcd(count_bcd), .point(point), .cycle_led(cycle_led),
    .fine_relay(fine_relay), .main_relay(main_relay), .menu_open(menu_open),
    .saved_count(saved_count));

// *** testbench/pbc_counter_bench.sv ***
// Purpose: register-driven scenarios for the pulse batch counter
// Assumes: shortened tenth-second and menu hold counts
// Notes:   relay modes set active high in most scenarios
`timescale 1ns/10ps

module pbc_counter_bench;
    import pbc_pkg::*;
    logic        mclk, rst, power_fail, wr, rd, hold, stop, clear_start;
    logic        key_enter, reset_key, go, slow, cin, busy;
    logic        cycle_led, fine_relay, main_relay, menu_open;
    logic [9:0]  restore_count, saved_count;
    logic [15:0] wdata, rdata;
    logic [11:0] count_bcd;
    logic [7:0]  n_req;
    logic [2:0]  point;
    pbc_addr_t   addr;
    pbc_pins_s   pins;
    int          fails, checked;
    assign pins = '{count_in: cin, hold: hold, stop: stop, clear_start: clear_start,
                    key_enter: key_enter, reset_key: reset_key};
    pbc_counter #(.TENTH_CYC(10), .MENU_HOLD_CYC(20)) i_pbc_counter (
        .mclk(mclk), .rst(rst), .pins(pins), .power_fail(power_fail),
        .restore_count(restore_count), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .count_bcd(count_bcd), .point(point), .cycle_led(cycle_led),
        .fine_relay(fine_relay), .main_relay(main_relay), .menu_open(menu_open),
        .saved_count(saved_count));
    pbc_sensor_model i_pbc_sensor_model (.mclk(mclk), .rst(rst), .n_req(n_req), .go(go),
        .slow(slow), .count_in(cin), .busy(busy));
    always #20 mclk = ~mclk;
    // ****************
    // access tasks
    // ****************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rly(input logic [1:0] e);
        chk({14'h0, fine_relay, main_relay}, {14'h0, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input pbc_addr_t a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input pbc_addr_t a, input logic [15:0] e, input logic [15:0] m);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    task automatic tap(input logic [1:0] k);
        @(posedge mclk);
        {reset_key, key_enter} <= k;
        @(posedge mclk);
        {reset_key, key_enter} <= 2'b00;
    endtask
    task automatic pulses(input logic [7:0] n);
        @(posedge mclk);
        n_req <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy)
            @(posedge mclk);
        settle(4);
    endtask
    task automatic close_out;
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge mclk);
        fails++;
        close_out;
    end
    // ****************
    // scenarios
    // ****************
    initial
    begin
        {mclk, rst, power_fail, wr, rd, hold, stop, clear_start} = 8'h40;
        {key_enter, reset_key, go, slow, addr, wdata, n_req} = '0;
        restore_count = 10'h07b;
        fails = 0;
        checked = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        settle(3);
        chk({4'h0, count_bcd}, 16'h0123);
        rly(2'b11);
        rd_chk(REG_PRESET, 16'h0064, 16'hffff);
        rd_chk(4'hf, 16'h0000, 16'hffff);
        @(posedge mclk);
        power_fail <= 1'b1;
        @(posedge mclk);
        power_fail <= 1'b0;
        settle(1);
        chk({6'h0, saved_count}, 16'h007b);
        wr_reg(REG_DIVIDER, 16'h0002);
        wr_reg(REG_MULT, 16'h0003);
        slow <= 1'b1;
        pulses(8'h04);
        slow <= 1'b0;
        rd_chk(REG_COUNT, 16'h0081, 16'hffff);
        wr_reg(REG_DIVIDER, 16'h0001);
        wr_reg(REG_MULT, 16'h0001);
        wr_reg(REG_CTRL, 16'h005a);
        wr_reg(REG_PRESET, 16'h0005);
        wr_reg(REG_ADVANCE, 16'h0002);
        wr_reg(REG_CMD, 16'h0001);
        settle(2);
        rly(2'b11);
        chk({13'h0, point}, 16'h0002);
        wr_reg(REG_PRESET, 16'h0007);
        pulses(8'h03);
        rly(2'b10);
        pulses(8'h02);
        rly(2'b00);
        chk({15'h0, cycle_led}, 16'h0000);
        rd_chk(REG_LATCHED, 16'h0005, 16'hffff);
        wr_reg(REG_CMD, 16'h0001);
        @(posedge mclk);
        hold <= 1'b1;
        pulses(8'h03);
        chk({4'h0, count_bcd}, 16'h0000);
        rd_chk(REG_STATUS, 16'h0001, 16'h0001);
        hold <= 1'b0;
        pulses(8'h01);
        chk({4'h0, count_bcd}, 16'h0001);
        stop <= 1'b1;
        settle(3);
        rly(2'b00);
        wr_reg(REG_CMD, 16'h0001);
        rd_chk(REG_STATUS, 16'h0000, 16'h0001);
        stop <= 1'b0;
        wr_reg(REG_CTRL, 16'h001b);
        wr_reg(REG_PRESET, 16'h0003);
        wr_reg(REG_ADVANCE, 16'h0004);
        @(posedge mclk);
        clear_start <= 1'b1;
        @(posedge mclk);
        clear_start <= 1'b0;
        settle(3);
        chk({4'h0, count_bcd}, 16'h0003);
        rly(2'b10);
        pulses(8'h03);
        chk({4'h0, count_bcd}, 16'h0000);
        rly(2'b00);
        wr_reg(REG_CTRL, 16'h0019);
        wr_reg(REG_PRESET, 16'h0000);
        tap(2'b10);
        tap(2'b01);
        rd_chk(REG_LATCHED, 16'h03e8, 16'hffff);
        pulses(8'h01);
        chk({4'h0, count_bcd}, 16'h0999);
        wr_reg(REG_CTRL, 16'h0018);
        pulses(8'h01);
        chk({4'h0, count_bcd}, 16'h0000);
        wr_reg(REG_CTRL, 16'h001e);
        wr_reg(REG_PRESET, 16'h0002);
        wr_reg(REG_DELAY, 16'h0005);
        wr_reg(REG_CMD, 16'h0001);
        pulses(8'h02);
        rd_chk(REG_STATUS, 16'h0002, 16'h0003);
        chk({15'h0, cycle_led}, 16'h0001);
        pulses(8'h01);
        chk({4'h0, count_bcd}, 16'h0003);
        chk({15'h0, cycle_led}, 16'h0000);
        settle(60);
        rd_chk(REG_STATUS, 16'h0001, 16'h0003);
        chk({4'h0, count_bcd}, 16'h0000);
        wr_reg(REG_DIVIDER, 16'h0001);
        pulses(8'h02);
        settle(60);
        rd_chk(REG_STATUS, 16'h0000, 16'h0003);
        wr_reg(REG_CMD, 16'h0001);
        tap(2'b01);
        settle(3);
        rly(2'b00);
        rd_chk(REG_STATUS, 16'h0004, 16'h0004);
        tap(2'b01);
        @(posedge mclk);
        key_enter <= 1'b1;
        settle(25);
        chk({15'h0, menu_open}, 16'h0001);
        key_enter <= 1'b0;
        close_out;
    end
endmodule
